/* hdl/afecfg_defs.svh */
`ifndef AFECFG_DEFS_SVH
`define AFECFG_DEFS_SVH

// Fixed seven-bit bus address, binary 1001000
`define AFECFG_BUS_ADDR 7'h48

// Register pointers
`define AFECFG_OFS_READY 8'h00
`define AFECFG_OFS_PROTECT 8'h01
`define AFECFG_OFS_GAIN 8'h10
`define AFECFG_OFS_REF 8'h11
`define AFECFG_OFS_MODE 8'h12

// Power-on values
`define AFECFG_RST_PROTECT 8'h01
`define AFECFG_RST_GAIN 8'h03
`define AFECFG_RST_REF 8'h20
`define AFECFG_RST_MODE 8'h00

// Field positions
`define AFECFG_READY_BIT 0
`define AFECFG_PROTECT_BIT 0
`define AFECFG_FB_MSB 4
`define AFECFG_FB_LSB 2
`define AFECFG_LOAD_MSB 1
`define AFECFG_LOAD_LSB 0
`define AFECFG_REFSRC_BIT 7
`define AFECFG_ZERO_MSB 6
`define AFECFG_ZERO_LSB 5
`define AFECFG_SIGN_BIT 4
`define AFECFG_BIAS_MSB 3
`define AFECFG_BIAS_LSB 0
`define AFECFG_SHORT_BIT 7
`define AFECFG_MODE_MSB 2
`define AFECFG_MODE_LSB 0

// Operating mode codes
`define AFECFG_MODE_DEEP_SLEEP 3'h0
`define AFECFG_MODE_GALVANIC 3'h1
`define AFECFG_MODE_STANDBY 3'h2
`define AFECFG_MODE_AMPERO 3'h3
`define AFECFG_MODE_TEMP_AMP_OFF 3'h6
`define AFECFG_MODE_TEMP_AMP_ON 3'h7

// Byte framing on the link
`define AFECFG_LAST_BIT 4'h7
`define AFECFG_BYTE_DONE 4'h8

// Power-on initialisation time and core clock period
`define AFECFG_POR_TIME_NS 1000
`define AFECFG_CLK_PERIOD_NS 100

`endif

/* hdl/afecfg_evt_rx.sv */
`timescale 1ns/10ps
`default_nettype none

// Turns a toggle from a foreign clock into a one-cycle local pulse
module afecfg_evt_rx (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tgl,
	output logic pulse
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic pulse;
	} afecfg_evt_st_t;

	afecfg_evt_st_t st_q; // Sync chain and pulse flop
	afecfg_evt_st_t st_d; // Next value

	// Edge is taken between stage two and three, never stage one
	always_comb begin
		st_d = st_q;
		st_d.s1 = tgl;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.pulse = st_q.s2 ^ st_q.s3;
	end

	// Toggles start low on both sides
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse = st_q.pulse;

endmodule

`default_nettype wire

/* hdl/afecfg_pkg.sv */
package afecfg_pkg;

	// Link-side transfer phases
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_ADDR,
		LK_PTR,
		LK_WR,
		LK_ACK,
		LK_RD,
		LK_RD_ACK
	} afecfg_link_st_t;

	// All state on the link clock
	typedef struct packed {
		afecfg_link_st_t st;
		afecfg_link_st_t nxt;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic wr_tgl;
		logic rd_tgl;
		logic [7:0] rd_byte;
		logic scl_d;
		logic sda_d;
		logic sda_oe;
		logic sda_o;
	} afecfg_link_t;

	// All state on the core clock
	typedef struct packed {
		logic ready;
		logic [15:0] por_cnt;
		logic protect;
		logic [2:0] fb_sel;
		logic [1:0] load_sel;
		logic ref_ext;
		logic [1:0] zero_sel;
		logic bias_pos;
		logic [3:0] bias_sel;
		logic short_en;
		logic [2:0] mode_sel;
		logic [7:0] rdata;
		logic ack_tgl;
		logic amp_en;
		logic tia_en;
		logic temp_en;
		logic analog_output_pin_temp;
		logic c2_pot;
	} afecfg_core_t;

endpackage

/* hdl/afecfg_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afecfg_defs.svh"

// What this block does
// - Ready bit low until ready; host waits.
// - Protect bit locks gain and reference registers.
// - Gain bits 4:2 pick feedback resistor.
// - Gain bits 1:0 pick load resistor.
// - Reference bit 7 picks external reference.
// - Reference bits 6:5 set internal zero.
// - Reference bit 4 sets bias polarity.
// - Reference bits 3:0 set bias magnitude.
// - Mode bit 7 enables electrode short switch.
// - Mode bits 2:0 select operating mode.
// - Temperature-amp-on routes temperature and potentiostat outputs.
// - Bus traffic only while module select low.
// - Answer only bus address 1001000.
// - Write is address, pointer, data, all acknowledged.
// - Read sets pointer, repeated start, returns byte.
module afecfg_regs
	import afecfg_pkg::*;
#(
	parameter int POR_CYCLES =
		(`AFECFG_POR_TIME_NS + `AFECFG_CLK_PERIOD_NS - 1) / `AFECFG_CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic module_select_n,
	output logic power_ready,
	output logic write_protect,
	output logic [2:0] feedback_resistor_sel,
	output logic [1:0] load_resistor_sel,
	output logic ref_source_ext,
	output logic [1:0] int_zero_sel,
	output logic bias_positive,
	output logic [3:0] bias_sel,
	output logic electrode_short_switch,
	output logic [2:0] operating_mode_sel,
	output logic control_amplifier_en,
	output logic transimpedance_amp_en,
	output logic temp_sensor_en,
	output logic analog_output_temp_sel,
	output logic feedback_node_potentiostat_sel
);

	// Power-on images of the registers, sliced into fields below
	localparam logic [7:0] RST_PROTECT = `AFECFG_RST_PROTECT;
	localparam logic [7:0] RST_GAIN = `AFECFG_RST_GAIN;
	localparam logic [7:0] RST_REF = `AFECFG_RST_REF;
	localparam logic [7:0] RST_MODE = `AFECFG_RST_MODE;
	localparam logic [6:0] BUS_ADDR = `AFECFG_BUS_ADDR;
	localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);
	localparam afecfg_link_t LINK_RST = '{
		st: LK_IDLE,
		nxt: LK_IDLE,
		scl_d: 1'b1,
		sda_d: 1'b1,
		default: '0
	};
	localparam afecfg_core_t CORE_RST = '{
		protect: RST_PROTECT[`AFECFG_PROTECT_BIT],
		fb_sel: RST_GAIN[`AFECFG_FB_MSB:`AFECFG_FB_LSB],
		load_sel: RST_GAIN[`AFECFG_LOAD_MSB:`AFECFG_LOAD_LSB],
		ref_ext: RST_REF[`AFECFG_REFSRC_BIT],
		zero_sel: RST_REF[`AFECFG_ZERO_MSB:`AFECFG_ZERO_LSB],
		bias_pos: RST_REF[`AFECFG_SIGN_BIT],
		bias_sel: RST_REF[`AFECFG_BIAS_MSB:`AFECFG_BIAS_LSB],
		short_en: RST_MODE[`AFECFG_SHORT_BIT],
		mode_sel: RST_MODE[`AFECFG_MODE_MSB:`AFECFG_MODE_LSB],
		default: '0
	};
	afecfg_link_t l_q; // Link-clock state
	afecfg_link_t l_d; // Its next value
	afecfg_core_t c_q; // Core-clock state
	afecfg_core_t c_d; // Its next value
	logic [2:0] pins_inv_s; // Inverted pins after two flops
	logic sel_n_s; // Module select after two flops
	logic scl_s; // Bus clock after two flops
	logic sda_s; // Bus data after two flops
	logic wr_p; // Core: a write byte is ready
	logic rd_p; // Core: the link wants read data
	logic ack_p; // Link: read data has arrived
	logic scl_rise; // Bus clock edges and bus conditions
	logic scl_fall;
	logic start_c;
	logic stop_c;
	// Pins are asynchronous to the link clock; they pass inverted so that a
	// cleared chain reads as an idle, deselected bus and makes no false edge
	afecfg_sync #(.W(3)) u_pin_sync (
		.clk(link_clk),
		.rst_b(rst_b),
		.d(~{module_select_n, scl, sda_in}),
		.q(pins_inv_s)
	);
	assign {sel_n_s, scl_s, sda_s} = ~pins_inv_s;
	// Written bytes travel to the core clock
	afecfg_evt_rx u_wr_rx (
		.clk(clk),
		.rst_b(rst_b),
		.tgl(l_q.wr_tgl),
		.pulse(wr_p)
	);
	// Read requests travel to the core clock
	afecfg_evt_rx u_rd_rx (
		.clk(clk),
		.rst_b(rst_b),
		.tgl(l_q.rd_tgl),
		.pulse(rd_p)
	);
	// Read replies travel back to the link clock
	afecfg_evt_rx u_ack_rx (
		.clk(link_clk),
		.rst_b(rst_b),
		.tgl(c_q.ack_tgl),
		.pulse(ack_p)
	);
	// Bus conditions seen on the synchronised lines
	assign scl_rise = scl_s && !l_q.scl_d;
	assign scl_fall = !scl_s && l_q.scl_d;
	assign start_c = scl_s && l_q.scl_d && l_q.sda_d && !sda_s;
	assign stop_c = scl_s && l_q.scl_d && !l_q.sda_d && sda_s;
	// Link-side byte engine; a low on the data line is driven through the enable
	always_comb begin
		l_d = l_q;
		l_d.scl_d = scl_s;
		l_d.sda_d = sda_s;
		// Reply words are stable once the toggle has crossed
		if (ack_p) begin
			l_d.rd_byte = c_q.rdata;
		end
		if (sel_n_s) begin
			// Deselected: drop any transfer and release the line
			l_d.st = LK_IDLE;
			l_d.sda_oe = 1'b0;
		end else if (start_c) begin
			// Start or repeated start always restarts address capture
			l_d.st = LK_ADDR;
			l_d.cnt = '0;
			l_d.sda_oe = 1'b0;
		end else if (stop_c) begin
			l_d.st = LK_IDLE;
			l_d.sda_oe = 1'b0;
		end else begin
			unique case (l_q.st)
				LK_IDLE: l_d.sda_oe = 1'b0;
				LK_ADDR, LK_PTR, LK_WR: begin
					if (scl_rise && l_q.cnt != `AFECFG_BYTE_DONE) begin
						// Shift in one bit per rising bus clock
						l_d.sh = {l_q.sh[6:0], sda_s};
						l_d.cnt = l_q.cnt + 4'h1;
						// Ask for read data early, so it is back before the first bit
						if (l_q.st == LK_ADDR && l_q.cnt == `AFECFG_LAST_BIT && sda_s
							&& l_q.sh[6:0] == BUS_ADDR) begin
							l_d.rd_tgl = ~l_q.rd_tgl;
						end
					end else if (scl_fall && l_q.cnt == `AFECFG_BYTE_DONE) begin
						// Whole byte in: acknowledge in the ninth clock
						l_d.cnt = '0;
						l_d.st = LK_ACK;
						l_d.sda_oe = 1'b1;
						if (l_q.st == LK_ADDR) begin
							if (l_q.sh[7:1] == BUS_ADDR) begin
								l_d.nxt = l_q.sh[0] ? LK_RD : LK_PTR;
							end else begin
								// Foreign address: no acknowledge, sit out the frame
								l_d.st = LK_IDLE;
								l_d.sda_oe = 1'b0;
							end
						end else if (l_q.st == LK_PTR) begin
							l_d.ptr = l_q.sh;
							l_d.nxt = LK_WR;
						end else begin
							// Further data bytes land on the same pointer
							l_d.wr_addr = l_q.ptr;
							l_d.wr_data = l_q.sh;
							l_d.wr_tgl = ~l_q.wr_tgl;
							l_d.nxt = LK_WR;
						end
					end
				end
				LK_ACK: begin
					if (scl_fall) begin
						// End of acknowledge: release, or present the first read bit
						l_d.st = l_q.nxt;
						l_d.cnt = '0;
						l_d.tx = l_q.rd_byte;
						l_d.sda_oe = (l_q.nxt == LK_RD) && !l_q.rd_byte[7];
					end
				end
				LK_RD: begin
					if (scl_fall) begin
						if (l_q.cnt == `AFECFG_LAST_BIT) begin
							// Eight bits out: let the host acknowledge
							l_d.sda_oe = 1'b0;
							l_d.st = LK_RD_ACK;
							l_d.cnt = '0;
						end else begin
							l_d.tx = {l_q.tx[6:0], 1'b0};
							l_d.sda_oe = !l_q.tx[6];
							l_d.cnt = l_q.cnt + 4'h1;
						end
					end
				end
				LK_RD_ACK: begin
					if (scl_rise) begin
						// Host not acknowledging ends the read
						if (sda_s) begin
							l_d.st = LK_IDLE;
						end else begin
							l_d.cnt = `AFECFG_BYTE_DONE;
						end
					end else if (scl_fall && l_q.cnt == `AFECFG_BYTE_DONE) begin
						// Host wants more: repeat the same register
						l_d.st = LK_RD;
						l_d.cnt = '0;
						l_d.tx = l_q.rd_byte;
						l_d.sda_oe = !l_q.rd_byte[7];
					end
				end
				default: begin
					l_d.st = LK_IDLE;
					l_d.sda_oe = 1'b0;
				end
			endcase
		end
	end
	// Link-clock register; the link clock may stand still between frames
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			l_q <= LINK_RST;
		end else begin
			l_q <= l_d;
		end
	end
	// Core side: register file, power-on ready and mode decode
	always_comb begin
		c_d = c_q;
		// Ready rises once the init count runs out and never falls again
		if (!c_q.ready) begin
			if (c_q.por_cnt == POR_LAST) begin
				c_d.ready = 1'b1;
			end else begin
				c_d.por_cnt = c_q.por_cnt + 16'h1;
			end
		end
		// Writes before ready are dropped; reserved bits are never stored
		if (wr_p && c_q.ready) begin
			unique case (l_q.wr_addr)
				`AFECFG_OFS_PROTECT: begin
					c_d.protect = l_q.wr_data[`AFECFG_PROTECT_BIT];
				end
				`AFECFG_OFS_GAIN: begin
					if (!c_q.protect) begin
						c_d.fb_sel = l_q.wr_data[`AFECFG_FB_MSB:`AFECFG_FB_LSB];
						c_d.load_sel = l_q.wr_data[`AFECFG_LOAD_MSB:`AFECFG_LOAD_LSB];
					end
				end
				`AFECFG_OFS_REF: begin
					if (!c_q.protect) begin
						c_d.ref_ext = l_q.wr_data[`AFECFG_REFSRC_BIT];
						c_d.zero_sel = l_q.wr_data[`AFECFG_ZERO_MSB:`AFECFG_ZERO_LSB];
						c_d.bias_pos = l_q.wr_data[`AFECFG_SIGN_BIT];
						c_d.bias_sel = l_q.wr_data[`AFECFG_BIAS_MSB:`AFECFG_BIAS_LSB];
					end
				end
				`AFECFG_OFS_MODE: begin
					// Mode is never write-protected
					c_d.short_en = l_q.wr_data[`AFECFG_SHORT_BIT];
					c_d.mode_sel = l_q.wr_data[`AFECFG_MODE_MSB:`AFECFG_MODE_LSB];
				end
				default: begin
					// Status and unmapped pointers take no write
				end
			endcase
		end
		// Read reply; pointer is stable while a request is in flight
		if (rd_p) begin
			unique case (l_q.ptr)
				`AFECFG_OFS_READY: c_d.rdata = {7'h00, c_q.ready};
				`AFECFG_OFS_PROTECT: c_d.rdata = {7'h00, c_q.protect};
				`AFECFG_OFS_GAIN: c_d.rdata = {3'h0, c_q.fb_sel, c_q.load_sel};
				`AFECFG_OFS_REF: begin
					c_d.rdata = {c_q.ref_ext, c_q.zero_sel, c_q.bias_pos, c_q.bias_sel};
				end
				`AFECFG_OFS_MODE: c_d.rdata = {c_q.short_en, 4'h0, c_q.mode_sel};
				default: c_d.rdata = 8'h00;
			endcase
			c_d.ack_tgl = ~c_q.ack_tgl;
		end
		// Analog block enables; undefined codes 100/101 fall back to all off
		c_d.amp_en = 1'b0;
		c_d.tia_en = 1'b0;
		c_d.temp_en = 1'b0;
		c_d.analog_output_pin_temp = 1'b0;
		c_d.c2_pot = 1'b0;
		unique case (c_d.mode_sel)
			`AFECFG_MODE_GALVANIC: begin
				// Control amplifier off, amplifier used non-inverting
				c_d.tia_en = 1'b1;
			end
			`AFECFG_MODE_STANDBY: begin
				c_d.amp_en = 1'b1;
			end
			`AFECFG_MODE_AMPERO: begin
				c_d.amp_en = 1'b1;
				c_d.tia_en = 1'b1;
			end
			`AFECFG_MODE_TEMP_AMP_OFF: begin
				c_d.amp_en = 1'b1;
				c_d.temp_en = 1'b1;
				c_d.analog_output_pin_temp = 1'b1;
			end
			`AFECFG_MODE_TEMP_AMP_ON: begin
				c_d.amp_en = 1'b1;
				c_d.tia_en = 1'b1;
				c_d.temp_en = 1'b1;
				c_d.analog_output_pin_temp = 1'b1;
				c_d.c2_pot = 1'b1;
			end
			default: begin
				// Deep sleep and undefined codes keep everything off
			end
		endcase
	end
	// Core-clock register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			c_q <= CORE_RST;
		end else begin
			c_q <= c_d;
		end
	end
	// All outputs come straight from state flops
	assign sda_out = l_q.sda_o;
	assign sda_oe = l_q.sda_oe;
	assign power_ready = c_q.ready;
	assign write_protect = c_q.protect;
	assign feedback_resistor_sel = c_q.fb_sel;
	assign load_resistor_sel = c_q.load_sel;
	assign ref_source_ext = c_q.ref_ext;
	assign int_zero_sel = c_q.zero_sel;
	assign bias_positive = c_q.bias_pos;
	assign bias_sel = c_q.bias_sel;
	assign electrode_short_switch = c_q.short_en;
	assign operating_mode_sel = c_q.mode_sel;
	assign control_amplifier_en = c_q.amp_en;
	assign transimpedance_amp_en = c_q.tia_en;
	assign temp_sensor_en = c_q.temp_en;
	assign analog_output_temp_sel = c_q.analog_output_pin_temp;
	assign feedback_node_potentiostat_sel = c_q.c2_pot;

endmodule

`default_nettype wire

/* hdl/afecfg_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a bundle of independent levels
module afecfg_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} afecfg_sync_st_t;

	afecfg_sync_st_t st_q; // Both stages
	afecfg_sync_st_t st_d; // Next value

	// First stage feeds only the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	// Stages clear to low at reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;

endmodule

`default_nettype wire

/* sim/afecfg_host.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afecfg_defs.svh"
// Bus master stand-in: open-drain data, clock and one select line
module afecfg_host
	import afecfg_pkg::*;
(
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low,
	output logic sel_n
);
	// Idle bus: clock high, data released, device not selected
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		sel_n = 1'b1;
	end
	// A third of a bus clock, five core cycles, so 500 ns at the 100 ns core clock
	task automatic half();
		repeat (5) @(posedge clk);
		#1;
	endtask
	// Data changes only with the clock low; sampled late in the high phase
	task automatic bit_x(input logic b, output logic s);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
		half();
	endtask
	// Start, also used as repeated start
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	// Stop: data rises while the clock is high
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask
	// One byte, MSB first; ninth bit released (ack from device, nack on read)
	task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], s);
			r[i] = s;
		end
		bit_x(1'b1, s);
		ack = !s;
	endtask
	// Write: address, pointer, data, each acknowledged
	task automatic wr(input logic en, input logic [6:0] adr, input logic [7:0] p,
		input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		sel_n = !en;
		half();
		start();
		xfer({adr, 1'b0}, r, a0);
		xfer(p, r, a1);
		xfer(d, r, a2);
		stop();
		sel_n = 1'b1;
		half();
		ok = a0 && a1 && a2;
	endtask
	// Read: pointer write, repeated start, one byte, nack
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		sel_n = 1'b0;
		half();
		start();
		xfer({`AFECFG_BUS_ADDR, 1'b0}, r, a0);
		xfer(p, r, a1);
		start();
		xfer({`AFECFG_BUS_ADDR, 1'b1}, r, a2);
		xfer(8'hff, d, a3);
		stop();
		sel_n = 1'b1;
		half();
		ok = a0 && a1 && a2;
	endtask
endmodule
`default_nettype wire

/* sim/afecfg_regs_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// Pin-level watcher for the configuration block
module afecfg_regs_chk
	import afecfg_pkg::*;
#(
	parameter int POR_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda_oe,
	input wire logic module_select_n,
	input wire logic power_ready,
	input wire logic write_protect,
	input wire logic [2:0] feedback_resistor_sel,
	input wire logic [1:0] load_resistor_sel,
	input wire logic [2:0] operating_mode_sel,
	input wire logic control_amplifier_en,
	input wire logic transimpedance_amp_en,
	input wire logic temp_sensor_en,
	input wire logic analog_output_temp_sel,
	input wire logic feedback_node_potentiostat_sel
);
	logic [7:0] cnt_q; // Core cycles since reset release
	logic [7:0] cnt_d;
	// Saturate so a long run never wraps back into the ready window
	always_comb begin
		cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
	end
	// Counter register, cleared by reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	a_ready_early: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(power_ready) |-> cnt_q >= POR_CYCLES - 1) else $error("ready flag rose early");
	a_ready_late: assert property (@(posedge clk) disable iff (!rst_b)
		cnt_q == POR_CYCLES + 3 |-> power_ready) else $error("ready flag rose late");
	a_ready_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		power_ready |=> power_ready) else $error("ready flag dropped");
	a_lock_freeze: assert property (@(posedge clk) disable iff (!rst_b)
		write_protect |-> $stable({feedback_resistor_sel, load_resistor_sel}))
		else $error("gain changed while protected");
	a_temp_route: assert property (@(posedge clk) disable iff (!rst_b)
		analog_output_temp_sel == (operating_mode_sel[2:1] == 2'b11))
		else $error("output routing wrong");
	a_node_route: assert property (@(posedge clk) disable iff (!rst_b)
		feedback_node_potentiostat_sel == (operating_mode_sel == 3'h7))
		else $error("feedback node routing wrong");
	a_amp_decode: assert property (@(posedge clk) disable iff (!rst_b)
		operating_mode_sel == 3'h3 |-> control_amplifier_en && transimpedance_amp_en
		&& !temp_sensor_en) else $error("three-lead decode wrong");
	a_sleep_off: assert property (@(posedge clk) disable iff (!rst_b)
		operating_mode_sel inside {3'h0, 3'h4, 3'h5} |-> !(control_amplifier_en
		|| transimpedance_amp_en || temp_sensor_en)) else $error("sleep decode wrong");
	a_unsel_quiet: assert property (@(posedge link_clk) disable iff (!rst_b)
		module_select_n [*6] |-> !sda_oe) else $error("data driven while unselected");
	a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rst_b)
		$changed(sda_oe) |-> !scl) else $error("data changed with clock high");
	c_ready: cover property (@(posedge clk) $rose(power_ready));
	c_unlock: cover property (@(posedge clk) $fell(write_protect));
	c_node: cover property (@(posedge clk) feedback_node_potentiostat_sel);
	c_ack: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule
bind afecfg_regs afecfg_regs_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
	.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl(scl), .sda_oe(sda_oe),
	.module_select_n(module_select_n), .power_ready(power_ready),
	.write_protect(write_protect), .feedback_resistor_sel(feedback_resistor_sel),
	.load_resistor_sel(load_resistor_sel), .operating_mode_sel(operating_mode_sel),
	.control_amplifier_en(control_amplifier_en),
	.transimpedance_amp_en(transimpedance_amp_en), .temp_sensor_en(temp_sensor_en),
	.analog_output_temp_sel(analog_output_temp_sel),
	.feedback_node_potentiostat_sel(feedback_node_potentiostat_sel)
);
`default_nettype wire

/* sim/afecfg_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afecfg_defs.svh"
// Self-checking bench: the master model walks the register map
module afecfg_regs_test
	import afecfg_pkg::*;
;
	logic clk, link_clk, rst_b, scl, sel_n, sda_out, sda_oe;
	logic sda_low; // Master pulls data low
	logic rdy, prot, rsrc, bpos, short_sw, tsel, c2sel;
	logic amp, transimpedance_amp, tsen; // Mode decode enables
	logic [2:0] fb, mode;
	logic [1:0] ld, zero;
	logic [3:0] bias;
	wire logic sda_w = !(sda_oe && !sda_out) && !sda_low; // Pulled-up line
	wire logic [7:0] gain_pins = {3'h0, fb, ld};
	wire logic [7:0] ref_pins = {rsrc, zero, bpos, bias};
	wire logic [7:0] mode_pins = {short_sw, 4'h0, mode};
	logic [7:0] ofs [5] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12};
	logic [7:0] msk [5] = '{8'h01, 8'h01, 8'h1f, 8'hff, 8'h87}; // Defined bits only
	logic [7:0] dflt [5] = '{8'h01, 8'h01, 8'h03, 8'h20, 8'h00};
	logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7}; // 101 undefined
	logic [2:0] ens [7] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h0, 3'h5, 3'h7}; // {amp, tia, temp}
	int err_count, n_compared;
	afecfg_regs #(.POR_CYCLES(10)) uut (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.module_select_n(sel_n), .power_ready(rdy), .write_protect(prot),
		.feedback_resistor_sel(fb), .load_resistor_sel(ld), .ref_source_ext(rsrc),
		.int_zero_sel(zero), .bias_positive(bpos), .bias_sel(bias),
		.electrode_short_switch(short_sw), .operating_mode_sel(mode),
		.control_amplifier_en(amp), .transimpedance_amp_en(transimpedance_amp), .temp_sensor_en(tsen),
		.analog_output_temp_sel(tsel), .feedback_node_potentiostat_sel(c2sel));
	afecfg_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low), .sel_n(sel_n));
	// Core clock, 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Link sampling clock, 6 ns, offset in phase
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register read, reserved bits masked off
	task automatic rchk(input logic [7:0] p, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd(p, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d & m, exp);
	endtask
	// Register write with the expected acknowledge outcome
	task automatic wchk(input logic [7:0] p, input logic [7:0] d, input logic en = 1'b1,
		input logic [6:0] adr = `AFECFG_BUS_ADDR, input logic ack = 1'b1);
		logic ok;
		host.wr(en, adr, p, d, ok);
		chk({7'h00, ok}, {7'h00, ack});
	endtask
	// Single place where the run ends
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Watchdog, about three and a half times the expected run
	initial begin
		#6000000;
		err_count++;
		close_out();
	end
	// Main sequence
	initial begin
		logic [7:0] d;
		logic ok;
		err_count = 0;
		n_compared = 0;
		rst_b = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk({1'b0, rdy, prot, fb, ld}, 8'h23);
		chk(ref_pins, 8'h20);
		d = 8'h00;
		for (int i = 0; i < 8 && d[0] !== 1'b1; i++) host.rd(8'h00, d, ok);
		chk(d & 8'h01, 8'h01);
		for (int i = 0; i < 5; i++) rchk(ofs[i], msk[i], dflt[i]);
		$display("test power_on done");
		wchk(8'h10, 8'h1c);
		wchk(8'h11, 8'h9d);
		rchk(8'h10, 8'h1f, 8'h03);
		chk(ref_pins, 8'h20);
		for (int i = 0; i < 7; i++) begin
			d = {!i[0], 4'h0, modes[i]};
			wchk(8'h12, d);
			chk(mode_pins, d);
			chk({5'h0, amp, transimpedance_amp, tsen}, {5'h0, ens[i]});
			chk({6'h0, tsel, c2sel}, {6'h0, modes[i][2:1] == 2'b11, modes[i] == 3'h7});
		end
		rchk(8'h12, 8'h87, 8'h87);
		$display("test modes done");
		wchk(8'h01, 8'h00);
		chk({7'h0, prot}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			d = {3'h0, i[2:0], i[1:0]};
			wchk(8'h10, d);
			chk(gain_pins, d);
		end
		rchk(8'h10, 8'h1f, 8'h1f);
		wchk(8'h11, 8'hfd);
		chk(ref_pins, 8'hfd);
		wchk(8'h11, 8'h4c);
		chk(ref_pins, 8'h4c);
		rchk(8'h11, 8'hff, 8'h4c);
		$display("test unlocked done");
		wchk(8'h01, 8'h01);
		wchk(8'h10, 8'h00);
		chk(gain_pins, 8'h1f);
		wchk(8'h12, 8'h00, 1'b1, 7'h49, 1'b0);
		wchk(8'h12, 8'h00, 1'b0, `AFECFG_BUS_ADDR, 1'b0);
		chk(mode_pins, 8'h87);
		$display("test addressing done");
		close_out();
	end
endmodule
`default_nettype wire
